// ==== rtl/dptr_pkg.sv ====
// constants, types and table contents for the parameter table block
package dptr_pkg;

    // density options selectable by software
    typedef enum logic [2:0] {
        DPTR_DENS_4M   = 3'h0,
        DPTR_DENS_2M   = 3'h1,
        DPTR_DENS_1M   = 3'h2,
        DPTR_DENS_512K = 3'h3,
        DPTR_DENS_256K = 3'h4,
        DPTR_DENS_1M_C = 3'h5
    } dptr_density_e;

    // ahb request as seen by the slave
    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
        logic        hready;
    } dptr_ahb_req_s;

    // ahb answer from the slave
    typedef struct packed {
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        hresp;
    } dptr_ahb_rsp_s;

    localparam logic [2:0]  HSIZE_WORD      = 3'h2;
    localparam logic        HRESP_OKAY      = 1'h0;
    localparam logic [31:0] RDATA_UNMAPPED  = 32'h0000_0000;
    localparam logic [31:0] RDATA_UNUSED    = 32'hFFFF_FFFF;

    // header words that point at the basic table
    localparam logic [7:0]  OFS_HDR_LEN     = 8'h08;
    localparam logic [7:0]  OFS_HDR_PTR     = 8'h0C;
    localparam logic [7:0]  BASIC_TABLE_POINTER = 8'h30;
    localparam logic [7:0]  BASIC_TABLE_LEN = 8'h10;
    localparam logic [7:0]  BASIC_TABLE_END = 8'h70;
    localparam logic [7:0]  PARAM_ID_LSB    = 8'h00;
    localparam logic [7:0]  PARAM_ID_MSB    = 8'hFF;
    localparam logic [7:0]  PARAM_REV_MINOR = 8'h06;
    localparam logic [7:0]  PARAM_REV_MAJOR = 8'h01;

    // byte offsets of the table words in this block
    localparam logic [7:0]  OFS_W30 = 8'h30;
    localparam logic [7:0]  OFS_W34 = 8'h34;
    localparam logic [7:0]  OFS_W38 = 8'h38;
    localparam logic [7:0]  OFS_W3C = 8'h3C;
    localparam logic [7:0]  OFS_W40 = 8'h40;
    localparam logic [7:0]  OFS_W44 = 8'h44;
    localparam logic [7:0]  OFS_W48 = 8'h48;
    localparam logic [7:0]  OFS_W4C = 8'h4C;
    localparam logic [7:0]  OFS_W50 = 8'h50;
    localparam logic [7:0]  OFS_W54 = 8'h54;

    // control and status words
    localparam logic [7:0]  OFS_CFG  = 8'h80;
    localparam logic [7:0]  OFS_STAT = 8'h84;
    localparam dptr_density_e CFG_RESET = DPTR_DENS_4M;

    // bytes 30h and 31h fields
    localparam logic [1:0]  MIN_ERASE_CODE  = 2'h1;
    localparam logic        WRITE_GRAN_FLAG = 1'h1;
    localparam logic        VOLATILE_BP     = 1'h1;
    localparam logic        WREN_SELECT     = 1'h0;
    localparam logic [2:0]  UNUSED_3        = 3'h7;
    localparam logic [7:0]  OP_ERASE_4K     = 8'h20;

    // byte 32h flags, with the 2-2-2 and 4-4-4 flags in byte 40h
    localparam logic        SUP_112 = 1'h1;
    localparam logic [1:0]  ADDR_BYTES = 2'h0;
    localparam logic        SUP_DTR = 1'h0;
    localparam logic        SUP_122 = 1'h1;
    localparam logic        SUP_144 = 1'h1;
    localparam logic        SUP_114 = 1'h1;
    localparam logic        SUP_222 = 1'h0;
    localparam logic        SUP_444 = 1'h1;

    // fast read descriptors
    localparam logic [4:0]  DUMMY_144 = 5'h04;
    localparam logic [2:0]  MODE_144  = 3'h2;
    localparam logic [7:0]  OP_144    = 8'hEB;
    localparam logic [4:0]  DUMMY_114 = 5'h08;
    localparam logic [2:0]  MODE_114  = 3'h0;
    localparam logic [7:0]  OP_114    = 8'h6B;
    localparam logic [4:0]  DUMMY_112 = 5'h08;
    localparam logic [2:0]  MODE_112  = 3'h0;
    localparam logic [7:0]  OP_112    = 8'h3B;
    localparam logic [4:0]  DUMMY_122 = 5'h00;
    localparam logic [2:0]  MODE_122  = 3'h4;
    localparam logic [7:0]  OP_122    = 8'hBB;
    localparam logic [4:0]  DUMMY_222 = 5'h00;
    localparam logic [2:0]  MODE_222  = 3'h0;
    localparam logic [7:0]  OP_NONE   = 8'hFF;
    localparam logic [4:0]  DUMMY_444 = 5'h04;
    localparam logic [2:0]  MODE_444  = 3'h2;
    localparam logic [7:0]  OP_444    = 8'hEB;

    // density minus one, bytes 34h to 37h, only byte 36h varies
    localparam logic [7:0]  DENS_4M   = 8'h3F;
    localparam logic [7:0]  DENS_2M   = 8'h1F;
    localparam logic [7:0]  DENS_1M   = 8'h0F;
    localparam logic [7:0]  DENS_512K = 8'h07;
    localparam logic [7:0]  DENS_256K = 8'h03;
    localparam logic [7:0]  DENS_TOP  = 8'h00;
    localparam logic [15:0] DENS_LOW  = 16'hFFFF;

    // erase types
    localparam logic [7:0]  ER1_SIZE = 8'h0C;
    localparam logic [7:0]  ER1_OP   = 8'h20;
    localparam logic [7:0]  ER2_SIZE = 8'h0F;
    localparam logic [7:0]  ER2_OP   = 8'h52;
    localparam logic [7:0]  ER3_SIZE = 8'h10;
    localparam logic [7:0]  ER3_OP   = 8'hD8;
    localparam logic [7:0]  ER_NONE_SIZE = 8'h00;

    // typical erase times
    localparam logic [3:0]  ER_MULT   = 4'h2;
    localparam logic [4:0]  ER12_CNT  = 5'h04;
    localparam logic [1:0]  ER12_UNIT = 2'h1;
    localparam logic [4:0]  ER3_CNT   = 5'h0C;
    localparam logic [1:0]  ER3_UNIT  = 2'h1;
    localparam logic [4:0]  ER_NONE_CNT  = 5'h00;
    localparam logic [1:0]  ER_NONE_UNIT = 2'h0;

endpackage : dptr_pkg

// ==== rtl/dptr_table_rom.sv ====
// ahb-lite slave serving the discoverable parameter table contents
module dptr_table_rom
(
    // clock and reset
    input  wire logic                   clock_i,
    input  wire logic                   rst_b_i,
    // ahb-lite slave
    input  wire dptr_pkg::dptr_ahb_req_s ahb_req_i,
    output      dptr_pkg::dptr_ahb_rsp_s ahb_rsp_o,
    // erase decode hint for the command logic
    output      logic                   d8_block_32k_o,
    output      logic                   large_density_o
);

    dptr_pkg::dptr_density_e cfg_reg;
    dptr_pkg::dptr_density_e cfg_next;
    logic                    wr_pend_reg;
    logic [31:0]             rdata_reg;
    logic                    d8_alias_reg;
    logic                    large_reg;
    logic                    addr_phase;
    logic                    cfg_large;
    logic                    cfg_d8_alias;
    logic [31:0]             rd_word;

    // a transfer is accepted when selected, active and the bus is ready
    assign addr_phase = ahb_req_i.hsel && ahb_req_i.htrans[1]
                        && ahb_req_i.hready;

    // illegal density codes are dropped so the table never goes undefined
    always_comb
    begin
        cfg_next = cfg_reg;
        if (wr_pend_reg && ahb_req_i.hready
            && (ahb_req_i.hwdata[2:0] <= dptr_pkg::DPTR_DENS_1M_C))
        begin
            cfg_next = dptr_pkg::dptr_density_e'(ahb_req_i.hwdata[2:0]);
        end
    end

    always_comb
    begin
        cfg_large = (cfg_next == dptr_pkg::DPTR_DENS_4M)
                    || (cfg_next == dptr_pkg::DPTR_DENS_2M)
                    || (cfg_next == dptr_pkg::DPTR_DENS_1M);
        cfg_d8_alias = !cfg_large;
    end

    // read mux works on the post-write config so back-to-back
    // write then read of the config word sees the new value
    always_comb
    begin
        rd_word = dptr_pkg::RDATA_UNMAPPED;
        if (ahb_req_i.haddr[31:8] == 24'h00_0000)
        begin
            if ((ahb_req_i.haddr[7:0] >= dptr_pkg::BASIC_TABLE_POINTER)
                && (ahb_req_i.haddr[7:0] < dptr_pkg::BASIC_TABLE_END))
            begin
                rd_word = dptr_pkg::RDATA_UNUSED;
            end
            unique case ({ahb_req_i.haddr[7:2], 2'h0})
                dptr_pkg::OFS_HDR_LEN:
                    rd_word = {dptr_pkg::BASIC_TABLE_LEN,
                               dptr_pkg::PARAM_REV_MAJOR,
                               dptr_pkg::PARAM_REV_MINOR,
                               dptr_pkg::PARAM_ID_LSB};
                dptr_pkg::OFS_HDR_PTR:
                    rd_word = {dptr_pkg::PARAM_ID_MSB, 16'h0000,
                               dptr_pkg::BASIC_TABLE_POINTER};
                dptr_pkg::OFS_W30:
                    rd_word = {8'hFF, dptr_pkg::UNUSED_3[0:0],
                               dptr_pkg::SUP_114,
                               dptr_pkg::SUP_144,
                               dptr_pkg::SUP_122,
                               dptr_pkg::SUP_DTR,
                               dptr_pkg::ADDR_BYTES,
                               dptr_pkg::SUP_112,
                               dptr_pkg::OP_ERASE_4K,
                               dptr_pkg::UNUSED_3,
                               dptr_pkg::WREN_SELECT,
                               dptr_pkg::VOLATILE_BP,
                               dptr_pkg::WRITE_GRAN_FLAG,
                               dptr_pkg::MIN_ERASE_CODE};
                dptr_pkg::OFS_W34:
                begin
                    rd_word = {dptr_pkg::DENS_TOP, dptr_pkg::DENS_4M,
                               dptr_pkg::DENS_LOW};
                    unique case (cfg_next)
                        dptr_pkg::DPTR_DENS_2M:
                            rd_word[23:16] = dptr_pkg::DENS_2M;
                        dptr_pkg::DPTR_DENS_1M,
                        dptr_pkg::DPTR_DENS_1M_C:
                            rd_word[23:16] = dptr_pkg::DENS_1M;
                        dptr_pkg::DPTR_DENS_512K:
                            rd_word[23:16] = dptr_pkg::DENS_512K;
                        dptr_pkg::DPTR_DENS_256K:
                            rd_word[23:16] = dptr_pkg::DENS_256K;
                        default:
                            rd_word[23:16] = dptr_pkg::DENS_4M;
                    endcase
                end
                dptr_pkg::OFS_W38:
                    rd_word = {dptr_pkg::OP_114, dptr_pkg::MODE_114,
                               dptr_pkg::DUMMY_114,
                               dptr_pkg::OP_144, dptr_pkg::MODE_144,
                               dptr_pkg::DUMMY_144};
                dptr_pkg::OFS_W3C:
                    rd_word = {dptr_pkg::OP_122, dptr_pkg::MODE_122,
                               dptr_pkg::DUMMY_122,
                               dptr_pkg::OP_112, dptr_pkg::MODE_112,
                               dptr_pkg::DUMMY_112};
                dptr_pkg::OFS_W40:
                    rd_word = {24'hFF_FFFF, dptr_pkg::UNUSED_3,
                               dptr_pkg::SUP_444,
                               dptr_pkg::UNUSED_3,
                               dptr_pkg::SUP_222};
                dptr_pkg::OFS_W44:
                    rd_word = {dptr_pkg::OP_NONE, dptr_pkg::MODE_222,
                               dptr_pkg::DUMMY_222,
                               16'hFFFF};
                dptr_pkg::OFS_W48:
                    rd_word = {dptr_pkg::OP_444, dptr_pkg::MODE_444,
                               dptr_pkg::DUMMY_444,
                               16'hFFFF};
                dptr_pkg::OFS_W4C:
                    rd_word = {dptr_pkg::ER2_OP, dptr_pkg::ER2_SIZE,
                               dptr_pkg::ER1_OP,
                               dptr_pkg::ER1_SIZE};
                dptr_pkg::OFS_W50:
                    rd_word = {dptr_pkg::OP_NONE,
                               dptr_pkg::ER_NONE_SIZE,
                               cfg_large ? dptr_pkg::ER3_OP
                                         : dptr_pkg::OP_NONE,
                               cfg_large ? dptr_pkg::ER3_SIZE
                                         : dptr_pkg::ER_NONE_SIZE};
                dptr_pkg::OFS_W54:
                    rd_word = {dptr_pkg::ER_NONE_UNIT,
                               dptr_pkg::ER_NONE_CNT,
                               cfg_large ? dptr_pkg::ER3_UNIT
                                         : dptr_pkg::ER_NONE_UNIT,
                               cfg_large ? dptr_pkg::ER3_CNT
                                         : dptr_pkg::ER_NONE_CNT,
                               dptr_pkg::ER12_UNIT, dptr_pkg::ER12_CNT,
                               dptr_pkg::ER12_UNIT, dptr_pkg::ER12_CNT,
                               dptr_pkg::ER_MULT};
                dptr_pkg::OFS_CFG:
                    rd_word = {29'h0000_0000, cfg_next};
                dptr_pkg::OFS_STAT:
                    rd_word = {27'h000_0000, cfg_large, cfg_d8_alias,
                               cfg_next};
                default:
                    rd_word = rd_word;
            endcase
        end
    end

    // write to the config word is remembered across the address phase
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            wr_pend_reg <= 1'h0;
        else if (ahb_req_i.hready)
            wr_pend_reg <= addr_phase && ahb_req_i.hwrite
                           && (ahb_req_i.hsize == dptr_pkg::HSIZE_WORD)
                           && (ahb_req_i.haddr == {24'h00_0000,
                                                  dptr_pkg::OFS_CFG});
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            cfg_reg <= dptr_pkg::CFG_RESET;
        else
            cfg_reg <= cfg_next;
    end

    // read data is sampled at the address phase, so no wait states
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            rdata_reg <= dptr_pkg::RDATA_UNMAPPED;
        else if (ahb_req_i.hready)
            rdata_reg <= (addr_phase && !ahb_req_i.hwrite)
                         ? rd_word : dptr_pkg::RDATA_UNMAPPED;
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            d8_alias_reg <= 1'h0;
            large_reg    <= 1'h1;
        end
        else
        begin
            d8_alias_reg <= cfg_d8_alias;
            large_reg    <= cfg_large;
        end
    end

    assign ahb_rsp_o.hrdata    = rdata_reg;
    assign ahb_rsp_o.hreadyout = 1'h1;
    assign ahb_rsp_o.hresp     = dptr_pkg::HRESP_OKAY;
    assign d8_block_32k_o      = d8_alias_reg;
    assign large_density_o     = large_reg;

endmodule : dptr_table_rom

// ==== sim/dptr_host_model.sv ====
// host controller model: single-word bus master reading the table
module dptr_host_model
(
    // clock
    input  wire logic                    clock_i,
    // bus master side
    output      dptr_pkg::dptr_ahb_req_s ahb_req_o,
    input  wire dptr_pkg::dptr_ahb_rsp_s ahb_rsp_i
);
    timeunit 1ns;
    timeprecision 1ps;
    dptr_pkg::dptr_ahb_req_s req_reg = '0;
    dptr_pkg::dptr_ahb_rsp_s rsp_smp;
    // the one slave's hreadyout is the bus hready
    assign ahb_req_o = {req_reg[$bits(req_reg)-1:1], ahb_rsp_i.hreadyout};
    // slave outputs move after rising edges, so mid-cycle equals edge value
    always @(negedge clock_i) rsp_smp = ahb_rsp_i;
    // little-endian byte n of a table word
    function automatic logic [7:0] byte_of(input logic [31:0] w,
                                           input logic [1:0]  n);
        return w[8*n +: 8];
    endfunction : byte_of
    task automatic wait_rdy(inout int n);
        do @(posedge clock_i); while (rsp_smp.hreadyout !== 1'b1 && ++n < 64);
    endtask : wait_rdy
    // entered just after a rising edge; returns at the data-phase edge
    task automatic xfer(input logic [31:0] a, input logic w,
                        input logic [2:0] sz, input logic [31:0] wd,
                        output logic [31:0] rd, output logic ok);
        int n;
        n = 0;
        req_reg.hsel   <= 1'b1;
        req_reg.haddr  <= a;
        req_reg.htrans <= 2'h2;
        req_reg.hwrite <= w;
        req_reg.hsize  <= sz;
        wait_rdy(n);
        req_reg.hsel   <= 1'b0;
        req_reg.htrans <= 2'h0;
        req_reg.hwdata <= wd;
        wait_rdy(n);
        rd = rsp_smp.hrdata;
        ok = n < 64;
    endtask : xfer
endmodule : dptr_host_model

// ==== sim/dptr_table_monitor.sv ====
// checker for the parameter table slave, bound to its ports
module dptr_table_monitor
(
    // clock and reset
    input wire logic                    clock_i,
    input wire logic                    rst_b_i,
    // bus and hints
    input wire dptr_pkg::dptr_ahb_req_s ahb_req_i,
    input wire dptr_pkg::dptr_ahb_rsp_s ahb_rsp_o,
    input wire logic                    d8_block_32k_o,
    input wire logic                    large_density_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        rd_reg;
    logic [31:0] adr_reg;
    wire  [31:0] d = ahb_rsp_o.hrdata;
    // address of the read now in its data phase, all ones when idle;
    // a plain net so the properties see its sampled value, not the
    // value already updated at the same edge
    wire  [31:0] rd_adr = rd_reg ? adr_reg : 32'hFFFF_FFFF;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    // remember which read sits in its data phase
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rd_reg  <= 1'b0;
            adr_reg <= 32'h0;
        end
        else if (ahb_req_i.hready)
        begin
            rd_reg  <= ahb_req_i.hsel && ahb_req_i.htrans[1]
                       && !ahb_req_i.hwrite;
            adr_reg <= ahb_req_i.haddr;
        end
    end
    ptr_word_a: assert property (
        rd_adr == 32'h0C |-> d == 32'hFF000030)
        else $error("pointer word wrong");
    len_word_a: assert property (
        rd_adr == 32'h08 |-> d == 32'h10010600)
        else $error("length word wrong");
    caps_word_a: assert property (
        rd_adr == 32'h30 |-> d == 32'hFFF120ED)
        else $error("capability word wrong");
    quad_desc_a: assert property (
        rd_adr == 32'h38 |-> d == 32'h6B08EB44)
        else $error("quad read word wrong");
    dual_desc_a: assert property (
        rd_adr == 32'h3C |-> d == 32'hBB803B08)
        else $error("dual read word wrong");
    wide_flag_a: assert property (
        rd_adr == 32'h40 |-> d == 32'hFFFFFFFE)
        else $error("wide read flags wrong");
    erase_pair_a: assert property (
        rd_adr == 32'h4C |-> d == 32'h520F200C)
        else $error("erase types 1 and 2 wrong");
    erase_big_a: assert property (
        rd_adr == 32'h50 |-> d == (large_density_o ? 32'hFF00D810
                                                   : 32'hFF00FF00))
        else $error("erase type 3 word wrong");
    dens_word_a: assert property (
        rd_adr == 32'h34 |-> d[31:24] == 8'h00 && d[15:0] == 16'hFFFF)
        else $error("density word wrong");
    erase_time_a: assert property (
        rd_adr == 32'h54 |-> d[17:0] == 18'h12242 && d[31:25] == 7'h00)
        else $error("erase times wrong");
    size_hint_a: assert property (
        d8_block_32k_o != large_density_o)
        else $error("erase hints disagree");
    unused_word_a: assert property (
        rd_adr inside {[32'h58:32'h6C]} |-> d == 32'hFFFFFFFF)
        else $error("unused word wrong");
endmodule : dptr_table_monitor

bind dptr_table_rom dptr_table_monitor mon_u
(
    .clock_i         (clock_i),
    .rst_b_i         (rst_b_i),
    .ahb_req_i       (ahb_req_i),
    .ahb_rsp_o       (ahb_rsp_o),
    .d8_block_32k_o  (d8_block_32k_o),
    .large_density_o (large_density_o)
);

// ==== sim/tb.sv ====
// self-checking bench for the parameter table slave
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct { logic [31:0] a; logic [31:0] e; } dptr_row_s;
    logic                    clock_i = 1'b0;
    logic                    rst_b_i = 1'b0;
    dptr_pkg::dptr_ahb_req_s req;
    dptr_pkg::dptr_ahb_rsp_s rsp;
    logic                    d8_o;
    logic                    big_o;
    logic [31:0]             rd;
    logic                    ok;
    int                      err_total = 0;
    int                      comparisons = 0;
    logic [7:0]              dens_tab [6] = '{8'h3F, 8'h1F, 8'h0F,
                                              8'h07, 8'h03, 8'h0F};
    dptr_row_s               rows [9] = '{
        '{32'h08, 32'h10010600},
        '{32'h0C, 32'hFF000030},
        '{32'h30, 32'hFFF120ED},
        '{32'h38, 32'h6B08EB44},
        '{32'h3C, 32'hBB803B08},
        '{32'h40, 32'hFFFFFFFE},
        '{32'h44, 32'hFF00FFFF},
        '{32'h48, 32'hEB44FFFF},
        '{32'h4C, 32'h520F200C}};
    always #2 clock_i = ~clock_i;
    dptr_table_rom dut_u
    (
        .clock_i         (clock_i),
        .rst_b_i         (rst_b_i),
        .ahb_req_i       (req),
        .ahb_rsp_o       (rsp),
        .d8_block_32k_o  (d8_o),
        .large_density_o (big_o)
    );
    dptr_host_model host_u
    (
        .clock_i   (clock_i),
        .ahb_req_o (req),
        .ahb_rsp_i (rsp)
    );
    task automatic finish_test();
        $display("comparisons %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic bus(input logic [31:0] a, input logic w,
                       input logic [2:0] sz, input logic [31:0] wd);
        host_u.xfer(a, w, sz, wd, rd, ok);
        if (!ok)
        begin
            err_total++;
            $display("[ERR] %0t bus wait ran out", $time);
            finish_test();
        end
    endtask : bus
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
        bus(a, 1'b0, 3'h2, 32'h0);
        check(rd, e);
    endtask : rd_chk
    initial
    begin
        repeat (2) @(posedge clock_i);
        check(rsp.hrdata, 32'h0);
        check({30'h0, rsp.hreadyout, rsp.hresp}, 32'h2);
        rst_b_i <= 1'b1;
        @(posedge clock_i);
        foreach (rows[i])
            rd_chk(rows[i].a, rows[i].e);
        $display("fixed table words done");
        for (int c = 0; c < 6; c++)
        begin
            bus(32'h80, 1'b1, 3'h2, 32'(c));
            repeat (2) @(posedge clock_i);
            check({30'h0, d8_o, big_o}, {30'h0, c > 2, c < 3});
            rd_chk(32'h34, {8'h00, dens_tab[c], 16'hFFFF});
            check({24'h0, host_u.byte_of(rd, 2'h2)},
                  {24'h0, dens_tab[c]});
            rd_chk(32'h50, c < 3 ? 32'hFF00D810
                               : 32'hFF00FF00);
            rd_chk(32'h54, c < 3 ? 32'h00B12242
                               : 32'h00012242);
            $display("density option %0d done", c);
        end
        // byte write, bad code and a table write must all be dropped
        bus(32'h80, 1'b1, 3'h0, 32'h0);
        bus(32'h80, 1'b1, 3'h2, 32'h7);
        bus(32'h30, 1'b1, 3'h2, 32'h0);
        rd_chk(32'h80, 32'h5);
        rd_chk(32'h84, 32'hD);
        rd_chk(32'h30, 32'hFFF120ED);
        rd_chk(32'h50, 32'hFF00FF00);
        rd_chk(32'h58, 32'hFFFFFFFF);
        rd_chk(32'h6C, 32'hFFFFFFFF);
        rd_chk(32'h100, 32'h0);
        $display("refused writes done");
        rst_b_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        check({30'h0, d8_o, big_o}, 32'h1);
        check(rsp.hrdata, 32'h0);
        check({30'h0, rsp.hreadyout, rsp.hresp}, 32'h2);
        rst_b_i <= 1'b1;
        @(posedge clock_i);
        rd_chk(32'h84, 32'h10);
        rd_chk(32'h50, 32'hFF00D810);
        $display("mid-run reset done");
        finish_test();
    end
endmodule : tb
